//--- rtl/idgb_pkg.sv
package idgb_pkg;
	// clock and chain rate
	localparam int CLK_HZ = 10_000_000;
	localparam int FS_HZ = 2000;
	localparam int SAMPLE_CYCLES = CLK_HZ / FS_HZ;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_Z_DV_FINE = 8'h38;
	localparam logic [7:0] IDX_Z_DV_MAIN = 8'h3a;
	localparam logic [7:0] IDX_X_OFS_LOWER = 8'h40;
	localparam logic [7:0] IDX_X_OFS_UPPER = 8'h42;
	localparam logic [7:0] IDX_Y_OFS_LOWER = 8'h44;
	localparam logic [7:0] IDX_Y_OFS_UPPER = 8'h46;
	localparam logic [7:0] IDX_Z_OFS_LOWER = 8'h48;
	localparam logic [7:0] IDX_Z_OFS_UPPER = 8'h4a;
	localparam logic [7:0] IDX_DECIMATION = 8'h5e;

	// field layout and reset values
	localparam int WORD_W = 16;
	localparam int NUM_OFS_WORDS = 6;
	localparam logic [15:0] OFS_RESET = 16'h0000;
	localparam logic [15:0] DEC_RESET = 16'h0000;
	localparam logic [31:0] DV_RESET = 32'h0000_0000;
	localparam logic [31:0] SAT_POS = 32'h7fff_ffff;
	localparam logic [31:0] SAT_NEG = 32'h8000_0000;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// clamp a wide signed result into the 32-bit two's complement range
	function automatic logic [31:0] idgb_sat32(input logic signed [41:0] v);
		if (v > $signed({10'h000, SAT_POS}))
			return SAT_POS;
		else if (v < $signed({10'h3ff, SAT_NEG}))
			return SAT_NEG;
		else
			return v[31:0];
	endfunction
endpackage

//--- rtl/idgb_chan_if.sv
interface idgb_chan_if;
	logic sampleValid;
	logic [31:0] rateIn;
	logic [31:0] offset;
	logic [31:0] rateOut;
	logic outValid;

	modport calc (
		input sampleValid,
		input rateIn,
		input offset,
		output rateOut,
		output outValid
	);
	modport feed (
		output sampleValid,
		output rateIn,
		output offset,
		input rateOut,
		input outValid
	);
endinterface

//--- rtl/idgb_rate_offset.sv
module idgb_rate_offset (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// one gyro axis
	idgb_chan_if.calc chan
);
	logic [31:0] rate_reg;
	logic valid_reg;
	logic signed [41:0] sumWide;

	// sign-extend both terms so the add cannot wrap before the clamp
	assign sumWide = 42'($signed(chan.rateIn)) + 42'($signed(chan.offset));
	assign chan.rateOut = rate_reg;
	assign chan.outValid = valid_reg;

	// offset lands right behind the factory stage, once per sample
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rate_reg <= 32'h0000_0000;
			valid_reg <= 1'b0;
		end else if (ce) begin
			valid_reg <= chan.sampleValid;
			if (chan.sampleValid)
				rate_reg <= idgb_pkg::idgb_sat32(sumWide);
		end
	end

	a_rate_offset_sum: assert property (@(posedge mclk)
		disable iff (rst || !ce)
		chan.sampleValid |=> chan.outValid && chan.rateOut ==
		idgb_pkg::idgb_sat32(42'($signed($past(chan.rateIn))) +
		42'($signed($past(chan.offset)))))
		else $error("corrected rate is not rate plus offset");
endmodule

//--- rtl/idgb_regs_top.sv
// Functional notes
// - the main velocity word is signed, +-400 m/sec, zero reads 0x0000.
// - the fine word carries sixteen further bits below the main word.
// - velocity words sit at 0x38 and 0x3a, read only, never saved.
// - read alone, the main word spans 0x8000 to 0x7fff in steps of one.
// - main over fine is one 32-bit value clamped to 0x80000000..7fffffff.
// - offsets act right after the factory stage, 2000 times a second.
// - only the per-sensor offsets are open to software, nothing else; here the decimation setting at 0x5e is writable too.
// - x gyro offset lower word at 0x40, upper word at 0x42.
// - y gyro offset lower word at 0x44, upper word at 0x46.
// - z gyro offset lower word at 0x48, upper word at 0x4a.
// - all six offset words read and write, reset to zero, kept in flash.
// - upper and lower words join into one 32-bit offset, upper on top.
// - the offset shares the two's complement scale of the rate output.
// - velocity change sums sample pairs over D = setting + 1 samples.
//
// Chosen here: the AXI4-Lite interface to the registers.
module idgb_regs_top #(
	parameter int SAMPLE_CYCLES = idgb_pkg::SAMPLE_CYCLES,
	parameter int DV_SHIFT = 1,
	parameter int ADDR_W = 10
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// factory-corrected sensor values, held stable by the factory stage
	input wire logic [31:0] accelZ,
	input wire logic [31:0] gyroRateX,
	input wire logic [31:0] gyroRateY,
	input wire logic [31:0] gyroRateZ,
	// flash restore of offset words
	input wire logic restoreValid,
	input wire logic [2:0] restoreSel,
	input wire logic [15:0] restoreWord,
	// chain outputs
	output logic sampleTick,
	output logic [31:0] gyroCorrX,
	output logic [31:0] gyroCorrY,
	output logic [31:0] gyroCorrZ,
	output logic gyroCorrValid,
	output logic [31:0] dvelZ,
	output logic dvelValid
);
	localparam int ACC_W = 42;

	// bus state
	logic awReady_reg, awReady_next;
	logic wReady_reg, wReady_next;
	logic awHeld_reg, awHeld_next;
	logic wHeld_reg, wHeld_next;
	logic [7:0] wrIdx_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic bValid_reg, bValid_next;
	logic [1:0] bResp_reg;
	logic arReady_reg, arReady_next;
	logic rValid_reg, rValid_next;
	logic [31:0] rData_reg;
	logic [1:0] rResp_reg;

	// register contents and chain state
	logic [15:0] ofsWord_reg [idgb_pkg::NUM_OFS_WORDS];
	logic [15:0] decim_reg;
	logic [31:0] dv_reg;
	logic dvValid_reg;
	logic [15:0] tickTimer_reg;
	logic tick_reg;
	logic [31:0] prevAccel_reg;
	logic signed [ACC_W-1:0] acc_reg, acc_next;
	logic [15:0] decCnt_reg;

	// write decode on the held address
	logic awTake, wTake, doWrite;
	logic wrOfs, wrDec, wrRo, wrOk;
	logic [2:0] wrSel;
	logic [15:0] wrMerged;
	logic [15:0] wrOld;
	assign awTake = ce && s_axi_awvalid && awReady_reg;
	assign wTake = ce && s_axi_wvalid && wReady_reg;
	assign doWrite = ce && awHeld_reg && wHeld_reg && !bValid_reg;
	assign wrOfs = wrIdx_reg >= idgb_pkg::IDX_X_OFS_LOWER &&
		wrIdx_reg <= idgb_pkg::IDX_Z_OFS_UPPER && !wrIdx_reg[0];
	assign wrSel = wrIdx_reg[3:1];
	assign wrDec = wrIdx_reg == idgb_pkg::IDX_DECIMATION;
	assign wrRo = wrIdx_reg == idgb_pkg::IDX_Z_DV_FINE ||
		wrIdx_reg == idgb_pkg::IDX_Z_DV_MAIN;
	assign wrOk = wrOfs || wrDec;
	assign wrMerged = {wStrb_reg[1] ? wData_reg[15:8] : wrOld[15:8],
		wStrb_reg[0] ? wData_reg[7:0] : wrOld[7:0]};

	assign wrOld = wrDec ? decim_reg : ofsWord_reg[wrSel];

	// write handshake: address and data land in either order
	assign awHeld_next = awTake ? 1'b1 : (doWrite ? 1'b0 : awHeld_reg);
	assign wHeld_next = wTake ? 1'b1 : (doWrite ? 1'b0 : wHeld_reg);
	assign bValid_next = doWrite || (bValid_reg && !(ce && s_axi_bready));
	assign awReady_next = !awHeld_next && !bValid_next;
	assign wReady_next = !wHeld_next && !bValid_next;

	// ready flags stay registered so outputs come from flip-flops
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			awReady_reg <= 1'b1;
			wReady_reg <= 1'b1;
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			bValid_reg <= 1'b0;
		end else if (ce) begin
			awReady_reg <= awReady_next;
			wReady_reg <= wReady_next;
			awHeld_reg <= awHeld_next;
			wHeld_reg <= wHeld_next;
			bValid_reg <= bValid_next;
		end
	end

	// payload capture and write answer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wrIdx_reg <= 8'h00;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
			bResp_reg <= idgb_pkg::RESP_OKAY;
		end else if (ce) begin
			if (awTake)
				wrIdx_reg <= s_axi_awaddr[9:2];
			if (wTake) begin
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (doWrite) // read-only and unmapped writes are refused
				bResp_reg <= wrOk ? idgb_pkg::RESP_OKAY : idgb_pkg::RESP_SLVERR;
		end
	end

	// offset words: bus write wins over a flash restore in the same cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < idgb_pkg::NUM_OFS_WORDS; i++)
				ofsWord_reg[i] <= idgb_pkg::OFS_RESET;
			decim_reg <= idgb_pkg::DEC_RESET;
		end else if (ce) begin
			if (doWrite && wrOfs)
				ofsWord_reg[wrSel] <= wrMerged;
			else if (restoreValid && restoreSel < 3'd6)
				ofsWord_reg[restoreSel] <= restoreWord;
			if (doWrite && wrDec)
				decim_reg <= wrMerged;
		end
	end

	// read decode; factory coefficients have no address at all
	logic arTake;
	logic [7:0] rdIdx;
	logic rdOfs, rdFine, rdMain, rdDec, rdOk;
	logic [15:0] rdWord;
	assign arTake = ce && s_axi_arvalid && arReady_reg;
	assign rdIdx = s_axi_araddr[9:2];
	assign rdOfs = rdIdx >= idgb_pkg::IDX_X_OFS_LOWER &&
		rdIdx <= idgb_pkg::IDX_Z_OFS_UPPER && !rdIdx[0];
	assign rdFine = rdIdx == idgb_pkg::IDX_Z_DV_FINE;
	assign rdMain = rdIdx == idgb_pkg::IDX_Z_DV_MAIN;
	assign rdDec = rdIdx == idgb_pkg::IDX_DECIMATION;
	assign rdOk = rdOfs || rdFine || rdMain || rdDec;
	assign rdWord = rdMain ? dv_reg[31:16] :
		rdFine ? dv_reg[15:0] :
		rdDec ? decim_reg :
		rdOfs ? ofsWord_reg[rdIdx[3:1]] : 16'h0000;
	assign rValid_next = arTake || (rValid_reg && !(ce && s_axi_rready));
	assign arReady_next = !rValid_next;

	// read channel: one read in flight, answer the cycle after the take
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			arReady_reg <= 1'b1;
			rValid_reg <= 1'b0;
			rData_reg <= 32'h0000_0000;
			rResp_reg <= idgb_pkg::RESP_OKAY;
		end else if (ce) begin
			arReady_reg <= arReady_next;
			rValid_reg <= rValid_next;
			if (arTake) begin
				rData_reg <= {16'h0000, rdWord};
				rResp_reg <= rdOk ? idgb_pkg::RESP_OKAY : idgb_pkg::RESP_SLVERR;
			end
		end
	end

	// internal sample clock: one tick every SAMPLE_CYCLES
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tickTimer_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (ce) begin
			tick_reg <= tickTimer_reg == 16'(SAMPLE_CYCLES - 1);
			if (tickTimer_reg == 16'(SAMPLE_CYCLES - 1))
				tickTimer_reg <= 16'h0000;
			else
				tickTimer_reg <= tickTimer_reg + 16'h0001;
		end
	end

	// pair sum of this and the previous sample, kept wide against overflow
	logic signed [ACC_W-1:0] pairSum, accScaled;
	logic lastOfPeriod;
	assign pairSum = ACC_W'($signed(accelZ)) + ACC_W'($signed(prevAccel_reg));
	assign lastOfPeriod = decCnt_reg == decim_reg;
	assign acc_next = acc_reg + pairSum;
	assign accScaled = acc_next >>> DV_SHIFT;

	// velocity change: accumulate D pairs, halve, clamp, publish
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prevAccel_reg <= 32'h0000_0000;
			acc_reg <= '0;
			decCnt_reg <= 16'h0000;
			dv_reg <= idgb_pkg::DV_RESET;
			dvValid_reg <= 1'b0;
		end else if (ce) begin
			dvValid_reg <= tick_reg && lastOfPeriod && !(doWrite && wrDec);
			if (doWrite && wrDec) begin
				// a new period length restarts the sum cleanly
				acc_reg <= '0;
				decCnt_reg <= 16'h0000;
			end else if (tick_reg) begin
				prevAccel_reg <= accelZ;
				if (lastOfPeriod) begin
					dv_reg <= idgb_pkg::idgb_sat32(accScaled);
					acc_reg <= '0;
					decCnt_reg <= 16'h0000;
				end else begin
					acc_reg <= acc_next;
					decCnt_reg <= decCnt_reg + 16'h0001;
				end
			end
		end
	end

	// three gyro axes, each with its own joined offset
	idgb_chan_if chan[3] ();
	assign chan[0].rateIn = gyroRateX;
	assign chan[1].rateIn = gyroRateY;
	assign chan[2].rateIn = gyroRateZ;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gAxis
			assign chan[g].sampleValid = tick_reg;
			assign chan[g].offset = {ofsWord_reg[2*g+1], ofsWord_reg[2*g]};
			idgb_rate_offset uCalc (
				.mclk(mclk),
				.rst(rst),
				.ce(ce),
				.chan(chan[g])
			);
		end
	endgenerate

	// ports
	assign s_axi_awready = awReady_reg;
	assign s_axi_wready = wReady_reg;
	assign s_axi_bvalid = bValid_reg;
	assign s_axi_bresp = bResp_reg;
	assign s_axi_arready = arReady_reg;
	assign s_axi_rvalid = rValid_reg;
	assign s_axi_rdata = rData_reg;
	assign s_axi_rresp = rResp_reg;
	assign sampleTick = tick_reg;
	assign gyroCorrX = chan[0].rateOut;
	assign gyroCorrY = chan[1].rateOut;
	assign gyroCorrZ = chan[2].rateOut;
	assign gyroCorrValid = chan[0].outValid;
	assign dvelZ = dv_reg;
	assign dvelValid = dvValid_reg;

	// helper counters that only the checks read
	logic [15:0] hGap;
	logic hTickSeen;
	logic [16:0] hTicks;
	logic hDvSeen;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hGap <= 16'h0000;
			hTickSeen <= 1'b0;
			hTicks <= 17'h00000;
			hDvSeen <= 1'b0;
		end else if (ce) begin
			hGap <= tick_reg ? 16'h0001 : hGap + 16'h0001;
			hTickSeen <= hTickSeen || tick_reg;
			if (doWrite && wrDec)
				hDvSeen <= 1'b0;
			else if (dvValid_reg)
				hDvSeen <= 1'b1;
			if (dvValid_reg)
				hTicks <= 17'h00000;
			else if (tick_reg)
				hTicks <= hTicks + 17'h00001;
		end
	end

	a_tick_period_exact: assert property (@(posedge mclk)
		disable iff (rst || !ce)
		tick_reg && hTickSeen |-> hGap == 16'(SAMPLE_CYCLES))
		else $error("sample ticks not SAMPLE_CYCLES apart");
	a_dv_period_length: assert property (@(posedge mclk)
		disable iff (rst || !ce)
		dvValid_reg && hDvSeen |-> hTicks == 17'(decim_reg) + 17'h00001)
		else $error("velocity period is not setting plus one samples");
	a_main_word_read: assert property (@(posedge mclk)
		disable iff (rst || !ce)
		arTake && rdMain |=> s_axi_rvalid && s_axi_rdata == {16'h0000,
		$past(dv_reg[31:16])} && s_axi_rresp == idgb_pkg::RESP_OKAY)
		else $error("main velocity word read wrong");
	a_fine_word_read: assert property (@(posedge mclk)
		disable iff (rst || !ce)
		arTake && rdFine |=> s_axi_rdata == {16'h0000, $past(dv_reg[15:0])})
		else $error("fine velocity word read wrong");
	a_ro_write_refused: assert property (@(posedge mclk)
		disable iff (rst || !ce)
		doWrite && wrRo |=> s_axi_bvalid && s_axi_bresp == idgb_pkg::RESP_SLVERR
		&& (dv_reg == $past(dv_reg) || $past(tick_reg)))
		else $error("write to velocity word not refused");
	a_offset_write_lands: assert property (@(posedge mclk)
		disable iff (rst || !ce)
		doWrite && wrOfs && wStrb_reg[1:0] == 2'b11 |=> s_axi_bvalid &&
		s_axi_bresp == idgb_pkg::RESP_OKAY && ofsWord_reg[$past(wrSel)] ==
		$past(wData_reg[15:0]))
		else $error("offset word not stored");
	a_unmapped_read_err: assert property (@(posedge mclk)
		disable iff (rst || !ce)
		arTake && !rdOk |=> s_axi_rresp == idgb_pkg::RESP_SLVERR &&
		s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_dv_clamp_range: assert property (@(posedge mclk)
		disable iff (rst || !ce)
		tick_reg && lastOfPeriod && !(doWrite && wrDec) && accScaled >
		$signed({10'h000, idgb_pkg::SAT_POS}) |=> dv_reg == idgb_pkg::SAT_POS)
		else $error("velocity change not clamped at positive limit");
endmodule

//--- bench/tb_imu_dvel_gyro_bias_regs.sv
module tb_imu_dvel_gyro_bias_regs;
	timeunit 1ns;
	timeprecision 1ns;

	// short sample period keeps the run brief
	localparam int SC = 10;

	logic mclk, rst, ce;
	logic [9:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [3:0] wrStrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] accelZ, gyroRateX, gyroRateY, gyroRateZ, rd;
	logic restoreValid;
	logic [2:0] restoreSel;
	logic [15:0] restoreWord;
	logic sampleTick, gyroCorrValid, dvelValid;
	logic [31:0] gyroCorrX, gyroCorrY, gyroCorrZ, dvelZ;
	logic [7:0] ofsIdx [6];
	logic [15:0] ofsVal [6];
	int errCount, numChecks, n;

	idgb_regs_top #(.SAMPLE_CYCLES(SC)) u_dut (
		.mclk(mclk), .rst(rst), .ce(ce),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .accelZ(accelZ),
		.gyroRateX(gyroRateX), .gyroRateY(gyroRateY), .gyroRateZ(gyroRateZ),
		.restoreValid(restoreValid), .restoreSel(restoreSel),
		.restoreWord(restoreWord), .sampleTick(sampleTick),
		.gyroCorrX(gyroCorrX), .gyroCorrY(gyroCorrY), .gyroCorrZ(gyroCorrZ),
		.gyroCorrValid(gyroCorrValid), .dvelZ(dvelZ), .dvelValid(dvelValid)
	);

	// 10 MHz clock
	always #50 mclk = ~mclk;

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		numChecks++;
		if (seen !== exp) begin
			errCount++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d);
		bit aw, w;
		int k;
		aw = 1;
		w = 1;
		k = 0;
		@(posedge mclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_wstrb <= wrStrb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while ((aw || w) && k < 200) begin
			@(posedge mclk);
			k++;
			if (aw && s_axi_awready === 1'b1) begin
				aw = 0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 0;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1 && k < 200) begin
			@(posedge mclk);
			k++;
		end
		chk("write answer", {31'h0, s_axi_bvalid}, 32'h1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] idx);
		int k;
		k = 0;
		@(posedge mclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			k++;
		end while (s_axi_arready !== 1'b1 && k < 200);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge mclk);
			k++;
		end while (s_axi_rvalid !== 1'b1 && k < 200);
		chk("read answer", {31'h0, s_axi_rvalid}, 32'h1);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wr_chk(input logic [7:0] i, input logic [31:0] d,
			input logic [1:0] r);
		axi_wr(i, d);
		chk("write response", {30'h0, resp}, {30'h0, r});
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] i,
			input logic [31:0] e, input logic [1:0] r);
		axi_rd(i);
		chk(nm, rd, e);
		chk("read response", {30'h0, resp}, {30'h0, r});
	endtask

	// expected velocity: (D pair sums) halved, clamped to 32 bits
	function automatic logic [31:0] dv_exp(input int dec, input logic [31:0] a);
		longint s;
		s = (longint'(signed'(a)) * 2 * (dec + 1)) >>> 1;
		if (s > 64'sh0000_0000_7fff_ffff)
			return 32'h7fff_ffff;
		if (s < -64'sh0000_0000_8000_0000)
			return 32'h8000_0000;
		return s[31:0];
	endfunction

	// third pulse after the change is free of the old sample in any period
	task automatic dv_case(input int dec, input logic [31:0] a);
		logic [31:0] e;
		int c;
		e = dv_exp(dec, a);
		accelZ <= a;
		wr_chk(idgb_pkg::IDX_DECIMATION, 32'(dec), idgb_pkg::RESP_OKAY);
		c = 0;
		for (int k = 0; k < 500 && c < 3; k++) begin
			@(posedge mclk);
			if (dvelValid === 1'b1)
				c++;
		end
		chk("dv pulses", 32'(c), 32'd3);
		chk("dvelZ", dvelZ, e);
		rd_chk("main word", idgb_pkg::IDX_Z_DV_MAIN, {16'h0, e[31:16]},
			idgb_pkg::RESP_OKAY);
		rd_chk("fine word", idgb_pkg::IDX_Z_DV_FINE, {16'h0, e[15:0]},
			idgb_pkg::RESP_OKAY);
		rd_chk("setting", idgb_pkg::IDX_DECIMATION, 32'(dec),
			idgb_pkg::RESP_OKAY);
	endtask

	task automatic wait_gyro;
		int c;
		c = 0;
		for (int k = 0; k < 100 && c < 2; k++) begin
			@(posedge mclk);
			if (gyroCorrValid === 1'b1)
				c++;
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// a hang cannot outlast this span; the tests need under a thousand cycles
	initial begin
		#(100 * 20000);
		errCount++;
		give_verdict;
	end

	initial begin
		mclk = 0;
		rst = 1;
		ce = 1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, restoreValid, restoreSel} = '0;
		{accelZ, gyroRateX, gyroRateY, gyroRateZ, restoreWord} = '0;
		wrStrb = 4'hf;
		ofsIdx = '{idgb_pkg::IDX_X_OFS_LOWER, idgb_pkg::IDX_X_OFS_UPPER,
			idgb_pkg::IDX_Y_OFS_LOWER, idgb_pkg::IDX_Y_OFS_UPPER,
			idgb_pkg::IDX_Z_OFS_LOWER, idgb_pkg::IDX_Z_OFS_UPPER};
		ofsVal = '{16'h0000, 16'h0001, 16'hffff, 16'hffff, 16'h0005, 16'h0000};
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++)
			rd_chk("offset reset", ofsIdx[i], 32'h0, 2'b00);
		$display("test reset values done");
		// upper half of the bus word must not reach the 16-bit register
		for (int i = 0; i < 6; i++) begin
			wr_chk(ofsIdx[i], 32'hbeef_0000 | (32'h1111 * (i + 1)), 2'b00);
			rd_chk("offset word", ofsIdx[i], 32'h1111 * (i + 1),
				2'b00);
		end
		// only the strobed byte lane may change
		wrStrb = 4'h2;
		wr_chk(idgb_pkg::IDX_X_OFS_LOWER, 32'h0000_ab00, 2'b00);
		wrStrb = 4'hf;
		rd_chk("strobed", idgb_pkg::IDX_X_OFS_LOWER, 32'h0000_ab11,
			2'b00);
		$display("test offset readback done");
		wr_chk(idgb_pkg::IDX_Z_DV_MAIN, 32'h1234, idgb_pkg::RESP_SLVERR);
		wr_chk(idgb_pkg::IDX_Z_DV_FINE, 32'h1234, idgb_pkg::RESP_SLVERR);
		wr_chk(8'h4c, 32'h1234, idgb_pkg::RESP_SLVERR);
		rd_chk("unmapped", 8'h3c, 32'h0, idgb_pkg::RESP_SLVERR);
		$display("test refused accesses done");
		for (int k = 0; k < 100 && sampleTick !== 1'b1; k++)
			@(posedge mclk);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (sampleTick !== 1'b1 && n < 100);
		chk("tick spacing", 32'(n), 32'(SC));
		$display("test sample rate done");
		// offsets +0x10000, -1, +5; x saturates
		for (int i = 0; i < 6; i++)
			wr_chk(ofsIdx[i], {16'h0, ofsVal[i]}, 2'b00);
		gyroRateX <= 32'h7fff_8000;
		gyroRateY <= 32'h0000_0010;
		gyroRateZ <= 32'hffff_fffe;
		wait_gyro;
		chk("gyroCorrX", gyroCorrX, 32'h7fff_ffff);
		chk("gyroCorrY", gyroCorrY, 32'h0000_000f);
		chk("gyroCorrZ", gyroCorrZ, 32'h0000_0003);
		wr_chk(idgb_pkg::IDX_Z_OFS_UPPER, 32'h1, 2'b00);
		wait_gyro;
		chk("gyroCorrZ new", gyroCorrZ, 32'h0001_0003);
		// a low enable must freeze the chain while its inputs move
		ce <= 1'b0;
		gyroRateY <= 32'h0000_0100;
		repeat (3 * SC) @(posedge mclk);
		chk("frozen gyroCorrY", gyroCorrY, 32'h0000_000f);
		ce <= 1'b1;
		wait_gyro;
		chk("thawed gyroCorrY", gyroCorrY, 32'h0000_00ff);
		$display("test offset chain done");
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk);
			restoreValid <= 1'b1;
			restoreSel <= 3'(i);
			restoreWord <= 16'h0100 + 16'(i);
			@(posedge mclk);
			restoreValid <= 1'b0;
			rd_chk("restored", ofsIdx[i], 32'h0100 + i, 2'b00);
		end
		$display("test flash restore done");
		dv_case(0, 32'h0000_0000);
		dv_case(0, 32'hffff_fffe);
		dv_case(1, 32'h0001_2345);
		dv_case(1, 32'h6000_0000);
		dv_case(1, 32'ha000_0000);
		dv_case(2, 32'h0000_0003);
		$display("test velocity change done");
		give_verdict;
	end
endmodule
